// *** core/iasc_pkg.sv ***
// package: register map, field positions, defaults and types of the serial config block
package iasc_pkg;
    localparam int          REG_COUNT      = 7;
    localparam logic [2:0]  ADDR_MAIN      = 3'h0;
    localparam logic [2:0]  ADDR_CLAMP_DIS = 3'h1;
    localparam logic [2:0]  ADDR_TGT_CTRL  = 3'h5;
    localparam logic [2:0]  ADDR_TGT_LEVEL = 3'h6;
    localparam logic [2:0]  ADDR_LAST      = 3'h6;
    localparam int          BIT_DEV_SEL    = 0;
    localparam int          BIT_MODE_LO    = 1;
    localparam int          BIT_EDGE       = 4;
    localparam int          BIT_FAST       = 5;
    localparam int          BIT_OUT_OFF    = 7;
    localparam int          BIT_CLAMP_OFF  = 6;
    localparam int          BIT_TGT_EN     = 0;
    localparam int          BIT_TGT_APPLY  = 1;
    localparam logic [7:0]  MAIN_RESET     = 8'h03;
    localparam logic [7:0]  ZERO_RESET     = 8'h00;
    localparam logic [9:0]  FIXED_TARGET   = 10'h1EC;
    localparam logic [2:0]  BIT_LAST       = 3'h7;
    localparam int          PIX_W          = 14;
    localparam logic [1:0]  MODE_STANDBY   = 2'h0;
    localparam logic [1:0]  MODE_GAIN6     = 2'h1;
    localparam logic [1:0]  MODE_TEST      = 2'h2;
    localparam logic [1:0]  MODE_GAIN0     = 2'h3;
    localparam int          FILT_SHIFT     = 4;
    localparam int          FAST_SHIFT     = 3;

    typedef struct packed {
        logic [1:0] mode;
        logic       update_falling;
        logic       fast_clamp;
        logic       outputs_off;
        logic       clamp_off;
        logic [9:0] clamp_target;
    } iasc_cfg_s;

    typedef struct packed {
        logic [7:0] shift;
        logic [2:0] bit_cnt;
        logic [2:0] addr;
        logic       full;
        logic       burst_ok;
        logic       wr_toggle;
        logic [2:0] wr_addr;
        logic [7:0] wr_data;
    } iasc_link_s;
endpackage : iasc_pkg

// *** core/iasc_config.sv ***
// serial config register bank with clamp loop and pixel output stage
//
// Operation
// [R1] bytes are eight bits, sent LSB first
// [R2] capture data on shift clock rise while strobe low
// [R3] strobe rise commits completed byte to register
// [R4] burst starts at address 0, auto-increments
// [R5] host always writes address 0 first
// [R6] device select bit must be one to write
// [R7] host holds reset low at least 10 us; the bench's second pulse in t_hard_reset lasts 8 clocks, 80 ns
// [R8] host drives serial lines defined after reset
// [R9] mode field: standby, 6 dB, test, 0 dB
// [R10] update edge select: rising or falling
// [R11] fast clamp halves loop time constant
// [R12] output disable tri-states pixel outputs
// [R13] clamp off bit disables black clamp loop
// [R14] target select: fixed 492 or programmable
// [R15] apply bit gates newly written target
// [R16] target code times four sets level
// [R17] pixel input sampled on sample clock rise
// [R18] clamp window: compare, filter, correct input
// [R19] host places clamp window over black pixels
// [R20] active-low reset restores register defaults
// [R21] host writes factory values to test registers
`timescale 1ns/100ps
module iasc_config (
    input  wire logic                  clock,
    input  wire logic                  reset,
    input  wire logic                  shift_clock,
    input  wire logic                  serial_load_strobe,
    input  wire logic                  serial_input_pin,
    input  wire logic                  hard_reset_n,
    input  wire logic                  sample_clock,
    input  wire logic                  black_clamp_window,
    input  wire logic [13:0]           pixel_input,
    output logic      [13:0]           pixel_output_bus,
    output logic                       pixel_output_oe_n,
    output logic      [13:0]           clamp_correction,
    output logic      [1:0]            operating_mode,
    output logic                       update_on_falling,
    output logic                       device_selected
);
    typedef struct packed {
        logic [2:0]                 sync_tog;
        logic [1:0]                 sync_rst;
        logic [1:0]                 sync_smp;
        logic [1:0]                 sync_win;
        logic                       smp_prev;
        logic [7:0]                 main_control;
        logic [7:0]                 clamp_disable_control;
        logic [7:0]                 factory_setting_a;
        logic [7:0]                 factory_setting_b;
        logic [7:0]                 factory_setting_c;
        logic [7:0]                 clamp_target_control;
        logic [7:0]                 clamp_target_level;
        logic [7:0]                 applied_level;
        logic [13:0]                sample;
        logic [13:0]                correction;
        logic [13:0]                pix_out;
        logic                       oe_n;
    } core_s;

    iasc_pkg::iasc_link_s link;
    iasc_pkg::iasc_link_s next_link;
    core_s                core;
    core_s                next_core;
    logic [1:0]           link_rst_sync;
    logic                 link_rst;
    logic [9:0]           target;
    logic signed [15:0]   err;
    logic [7:0]           wdata;
    logic [2:0]           waddr;

    // link-side reset: hard reset pin, released in the link domain
    always_ff @(posedge shift_clock or negedge hard_reset_n) begin
        if (!hard_reset_n) begin
            link_rst_sync <= 2'h3;
        end else begin
            link_rst_sync <= {link_rst_sync[0], 1'b0};
        end
    end
    assign link_rst = link_rst_sync[1];

    // shift logic runs on the shift clock; strobe rise is sampled there too
    always_comb begin
        next_link = link;
        if (serial_load_strobe) begin
            if (link.full && (link.burst_ok
                    || (link.addr == iasc_pkg::ADDR_MAIN
                        && link.shift[iasc_pkg::BIT_DEV_SEL]))) begin
                next_link.wr_toggle = ~link.wr_toggle; // [R3] [R6]
                next_link.wr_addr   = link.addr;
                next_link.wr_data   = link.shift;
            end
            next_link.addr     = iasc_pkg::ADDR_MAIN; // [R4]
            next_link.bit_cnt  = 3'h0;
            next_link.full     = 1'b0;
            next_link.burst_ok = 1'b0;
        end else begin
            // lsb first: shift in at the top, byte ends aligned
            next_link.shift = {serial_input_pin, link.shift[7:1]}; // [R1] [R2]
            next_link.bit_cnt = link.bit_cnt + 3'h1;
            if (link.full) begin
                if (link.addr == iasc_pkg::ADDR_MAIN) begin
                    next_link.burst_ok = link.shift[iasc_pkg::BIT_DEV_SEL];
                end
                if (link.burst_ok || (link.addr == iasc_pkg::ADDR_MAIN
                        && link.shift[iasc_pkg::BIT_DEV_SEL])) begin
                    next_link.wr_toggle = ~link.wr_toggle; // [R6]
                    next_link.wr_addr   = link.addr;
                    next_link.wr_data   = link.shift;
                end
                next_link.addr = link.addr + 3'h1; // [R4]
                next_link.full = 1'b0;
            end
            if (link.bit_cnt == iasc_pkg::BIT_LAST) begin
                next_link.full = 1'b1;
            end
        end
    end

    always_ff @(posedge shift_clock) begin
        if (link_rst) begin
            link <= '0;
        end else begin
            link <= next_link;
        end
    end

    assign wdata = link.wr_data;
    assign waddr = link.wr_addr;
    assign target = core.clamp_target_control[iasc_pkg::BIT_TGT_EN]
        ? {core.applied_level, 2'b00} // [R16]
        : iasc_pkg::FIXED_TARGET; // [R14]
    assign err = $signed({2'b00, core.sample}) - $signed({6'h00, target});

    always_comb begin
        next_core = core;
        next_core.sync_tog = {core.sync_tog[1:0], link.wr_toggle};
        next_core.sync_rst = {core.sync_rst[0], hard_reset_n};
        next_core.sync_smp = {core.sync_smp[0], sample_clock};
        next_core.sync_win = {core.sync_win[0], black_clamp_window};
        next_core.smp_prev = core.sync_smp[1];
        // data word is stable while the toggle crosses
        if (core.sync_tog[2] != core.sync_tog[1]) begin
            if (waddr == iasc_pkg::ADDR_MAIN) begin
                next_core.main_control = wdata;
            end else if (waddr == iasc_pkg::ADDR_CLAMP_DIS) begin
                next_core.clamp_disable_control = wdata;
            end else if (waddr == 3'h2) begin
                next_core.factory_setting_a = wdata;
            end else if (waddr == 3'h3) begin
                next_core.factory_setting_b = wdata;
            end else if (waddr == 3'h4) begin
                next_core.factory_setting_c = wdata;
            end else if (waddr == iasc_pkg::ADDR_TGT_CTRL) begin
                next_core.clamp_target_control = wdata;
            end else if (waddr == iasc_pkg::ADDR_TGT_LEVEL) begin
                next_core.clamp_target_level = wdata;
            end
        end
        if (core.clamp_target_control[iasc_pkg::BIT_TGT_APPLY]) begin
            next_core.applied_level = core.clamp_target_level; // [R15]
        end
        if (core.sync_smp[1] && !core.smp_prev) begin
            next_core.sample = pixel_input; // [R17]
            if (core.sync_win[1]
                && !core.clamp_disable_control[iasc_pkg::BIT_CLAMP_OFF]) begin
                // [R13] [R18] [R11]
                if (core.main_control[iasc_pkg::BIT_FAST]) begin
                    next_core.correction = core.correction
                        - 14'(err >>> iasc_pkg::FAST_SHIFT);
                end else begin
                    next_core.correction = core.correction
                        - 14'(err >>> iasc_pkg::FILT_SHIFT);
                end
            end
        end
        if (core.clamp_disable_control[iasc_pkg::BIT_CLAMP_OFF]) begin
            next_core.correction = 14'h0000; // [R13]
        end
        // [R10] update on chosen edge of the sampled clock
        if (core.main_control[iasc_pkg::BIT_EDGE]
                ? (!core.sync_smp[1] && core.smp_prev)
                : (core.sync_smp[1] && !core.smp_prev)) begin
            next_core.pix_out = core.sample;
        end
        if (core.main_control[2:1] == iasc_pkg::MODE_STANDBY) begin
            next_core.pix_out = 14'h0000; // [R9]
        end
        next_core.oe_n = core.main_control[iasc_pkg::BIT_OUT_OFF]; // [R12]
    end

    always_ff @(posedge clock) begin
        if (reset || !core.sync_rst[1]) begin
            // [R20]
            core <= '0;
            core.sync_rst              <= {core.sync_rst[0], hard_reset_n};
            core.main_control          <= iasc_pkg::MAIN_RESET;
            core.clamp_disable_control <= iasc_pkg::ZERO_RESET;
            core.oe_n                  <= 1'b0;
        end else begin
            core <= next_core;
        end
    end

    assign pixel_output_bus  = core.pix_out;
    assign pixel_output_oe_n = core.oe_n;
    assign clamp_correction  = core.correction;
    assign operating_mode    = core.main_control[2:1];
    assign update_on_falling = core.main_control[iasc_pkg::BIT_EDGE];
    assign device_selected   = core.main_control[iasc_pkg::BIT_DEV_SEL];

    a_reset_defaults: assert property (@(posedge clock)
        reset |=> operating_mode == iasc_pkg::MODE_GAIN6) // [R20] [R9]
        else $error("mode not default after reset");
    a_output_disable: assert property (@(posedge clock)
        disable iff (reset || !core.sync_rst[1])
        pixel_output_oe_n == $past(core.main_control[iasc_pkg::BIT_OUT_OFF]))
        else $error("output enable does not follow disable bit"); // [R12]
    a_clamp_off_zero: assert property (@(posedge clock) disable iff (reset)
        $past(core.clamp_disable_control[iasc_pkg::BIT_CLAMP_OFF])
            && !$past(reset) |-> clamp_correction == 14'h0000)
        else $error("clamp active while disabled"); // [R13]
    a_fixed_target: assert property (@(posedge clock) disable iff (reset)
        !core.clamp_target_control[iasc_pkg::BIT_TGT_EN]
            |-> target == iasc_pkg::FIXED_TARGET)
        else $error("fixed target wrong"); // [R14]
    a_apply_gate: assert property (@(posedge clock) disable iff (reset)
        !core.clamp_target_control[iasc_pkg::BIT_TGT_APPLY]
            && !core.sync_rst[1] == 1'b0
            |=> $stable(core.applied_level))
        else $error("target changed without apply"); // [R15]
    a_standby_quiet: assert property (@(posedge clock) disable iff (reset)
        operating_mode == iasc_pkg::MODE_STANDBY && !$past(reset)
            |=> pixel_output_bus == 14'h0000)
        else $error("output active in standby"); // [R9]
    a_write_needs_sel: assert property (@(posedge shift_clock)
        disable iff (link_rst)
        $changed(link.wr_toggle) && $past(link.addr) == iasc_pkg::ADDR_MAIN
            |-> link.wr_data[iasc_pkg::BIT_DEV_SEL])
        else $error("write committed without device select"); // [R6]
    a_addr_from_zero: assert property (@(posedge shift_clock)
        disable iff (link_rst)
        $past(serial_load_strobe) |-> link.addr == iasc_pkg::ADDR_MAIN)
        else $error("burst did not restart at zero"); // [R4]
    a_lsb_first: assert property (@(posedge shift_clock)
        disable iff (link_rst)
        !$past(serial_load_strobe)
            |-> link.shift[7] == $past(serial_input_pin))
        else $error("serial bit not shifted in"); // [R1] [R2]
endmodule : iasc_config

// *** tb/iasc_host_model.sv ***
// host timing controller model driving the three-wire serial link
`timescale 1ns/100ps
module iasc_host_model (
    output logic shift_clock,
    output logic serial_load_strobe,
    output logic serial_input_pin
);
    // shift clock rests low outside frames; lines start defined
    initial begin
        shift_clock        = 1'b0;
        serial_load_strobe = 1'b1;
        serial_input_pin   = 1'b0;
    end

    task automatic tick(input int n);
        repeat (n) begin
            #80 shift_clock = 1'b1;
            #80 shift_clock = 1'b0;
        end
    endtask : tick

    // burst from address 0 upward, bytes LSB first
    task automatic send(input logic [7:0] bytes [7], input int n);
        serial_load_strobe = 1'b0;
        for (int a = 0; a < n; a++) begin
            for (int i = 0; i < 8; i++) begin
                serial_input_pin = bytes[a][i];
                tick(1);
            end
        end
        // released data line must not look like the last bit
        serial_input_pin   = ~serial_input_pin;
        serial_load_strobe = 1'b1;
        tick(1);
    endtask : send
endmodule : iasc_host_model

// *** tb/test_imager_afe_serial_config.sv ***
// self-checking bench of the serial config block
`timescale 1ns/100ps
module test_imager_afe_serial_config;
    logic        clock = 1'b0;
    logic        reset = 1'b1;
    logic        hard_reset_n = 1'b1;
    logic        sample_clock = 1'b0;
    logic        black_clamp_window = 1'b0;
    logic [13:0] pixel_input = 14'h0000;
    logic        shift_clock, serial_load_strobe, serial_input_pin;
    logic [13:0] pixel_output_bus, clamp_correction;
    logic        pixel_output_oe_n, update_on_falling, device_selected;
    logic [1:0]  operating_mode;
    logic [7:0]  b [7];
    int          mismatches = 0;
    int          n_tests = 0;
    int          cycles = 0;

    always #5 clock = ~clock;

    iasc_config u_dut (
        .clock              (clock),
        .reset              (reset),
        .shift_clock        (shift_clock),
        .serial_load_strobe (serial_load_strobe),
        .serial_input_pin   (serial_input_pin),
        .hard_reset_n       (hard_reset_n),
        .sample_clock       (sample_clock),
        .black_clamp_window (black_clamp_window),
        .pixel_input        (pixel_input),
        .pixel_output_bus   (pixel_output_bus),
        .pixel_output_oe_n  (pixel_output_oe_n),
        .clamp_correction   (clamp_correction),
        .operating_mode     (operating_mode),
        .update_on_falling  (update_on_falling),
        .device_selected    (device_selected)
    );

    iasc_host_model u_host (
        .shift_clock        (shift_clock),
        .serial_load_strobe (serial_load_strobe),
        .serial_input_pin   (serial_input_pin)
    );

    // pixel stream, sample clock and clamp window on falling edges
    always @(negedge clock) begin
        cycles <= cycles + 1;
        sample_clock <= ~sample_clock;
        if (sample_clock) pixel_input <= pixel_input + 14'h0025;
        black_clamp_window <= (cycles % 200) < 60;
        if (cycles == 60000) begin
            mismatches = mismatches + 1;
            stop_test();
        end
    end

    task automatic check(input logic [15:0] got, input logic [15:0] exp);
        n_tests = n_tests + 1;
        if (got !== exp) begin
            mismatches = mismatches + 1;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : check

    // burst of n bytes with factory values in the fixed registers
    task automatic wr(input logic [7:0] main, input int n);
        b = '{main, 8'h00, 8'h48, 8'h63, 8'h10, 8'h01, 8'h7B};
        u_host.send(b, n);
        repeat (12) @(negedge clock);
    endtask : wr

    task automatic t_defaults;
        check({14'h0, operating_mode}, 16'h0001);
        check({15'h0, update_on_falling}, 16'h0000);
        check({15'h0, device_selected}, 16'h0001);
        check({15'h0, pixel_output_oe_n}, 16'h0000);
    endtask : t_defaults

    // every mode, with edge and output disable varied alongside
    task automatic t_modes;
        logic [1:0] m;
        for (int k = 0; k < 4; k++) begin
            m = 2'(k);
            wr({m[1], 2'b00, m[0], 1'b0, m, 1'b1}, 1);
            check({14'h0, operating_mode}, {14'h0, m});
            check({15'h0, update_on_falling}, {15'h0, m[0]});
            check({15'h0, pixel_output_oe_n}, {15'h0, m[1]});
            if (m == 2'h0)
                check({2'h0, pixel_output_bus}, 16'h0000);
        end
    endtask : t_modes

    task automatic t_refused;
        wr(8'h03, 7);
        wr(8'h96, 7);
        check({14'h0, operating_mode}, 16'h0001);
        check({15'h0, update_on_falling}, 16'h0000);
        check({15'h0, pixel_output_oe_n}, 16'h0000);
    endtask : t_refused

    // clamp off forces zero correction; clamp on moves it off zero
    task automatic t_clamp;
        b = '{8'h03, 8'h40, 8'h48, 8'h63, 8'h10, 8'h03, 8'h7B};
        u_host.send(b, 2);
        repeat (300) @(negedge clock);
        check({2'h0, clamp_correction}, 16'h0000);
        b[1] = 8'h00;
        u_host.send(b, 2);
        repeat (300) @(negedge clock);
        check({15'h0, clamp_correction != 14'h0}, 16'h0001);
        check({15'h0, pixel_output_bus != 14'h0}, 16'h0001);
    endtask : t_clamp

    task automatic t_hard_reset;
        wr(8'h97, 7);
        check({14'h0, operating_mode}, 16'h0003);
        hard_reset_n = 1'b0;
        repeat (8) @(negedge clock);
        t_defaults();
        hard_reset_n = 1'b1;
        u_host.tick(2);
        wr(8'h05, 1);
        check({14'h0, operating_mode}, 16'h0002);
    endtask : t_hard_reset

    task automatic stop_test;
        $display("comparisons %0d mismatches %0d", n_tests, mismatches);
        if (mismatches == 0 && n_tests > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask : stop_test

    initial begin
        // a real falling edge of the hard reset clears the link side
        @(negedge clock);
        hard_reset_n = 1'b0;
        repeat (11) @(negedge clock);
        reset = 1'b0;
        repeat (1000) @(negedge clock);
        hard_reset_n = 1'b1;
        u_host.tick(2);
        repeat (4) @(negedge clock);
        t_defaults();
        t_modes();
        t_refused();
        t_clamp();
        t_hard_reset();
        stop_test();
    end
endmodule : test_imager_afe_serial_config
